/* inc/urt_cfg.svh */
// Register offsets, field positions and trigger levels of one serial channel.
// Assumes a three-bit register address and an eight-bit data bus.
`ifndef URT_CFG_SVH
`define URT_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define URT_OFS_HOLD    3'h0
`define URT_OFS_IEN     3'h1
`define URT_OFS_ISTAT   3'h2
`define URT_OFS_LCTL    3'h3
`define URT_OFS_MCTL    3'h4
`define URT_OFS_LSTAT   3'h5
`define URT_OFS_MSTAT   3'h6
`define URT_OFS_SCR     3'h7

// ****************************************
// Field positions
// ****************************************
`define URT_LCTL_DIVEN  7
`define URT_FCTL_EN     0
`define URT_FCTL_RXCLR  1
`define URT_FCTL_TXCLR  2
`define URT_FCTL_DMA    3
`define URT_IEN_RXD     0
`define URT_IEN_TXE     1
`define URT_IEN_LS      2
`define URT_IEN_MS      3
`define URT_MCTL_GATE   3

// ****************************************
// Reset values and trigger levels
// ****************************************
`define URT_RST_BYTE    8'h00
`define URT_TRIG_L0     5'h01
`define URT_TRIG_L1     5'h04
`define URT_TRIG_L2     5'h08
`define URT_TRIG_L3     5'h0E
`define URT_FIFO_DEPTH  16

`endif

/* inc/urt_pkg.sv */
// Types shared by the serial channel register block.
// Assumes nothing of its surroundings.
package urt_pkg;
    typedef logic [7:0] urt_byte_t;
    typedef logic [2:0] urt_addr_t;

    // Interrupt source codes, highest priority first
    typedef enum logic [3:0] {
        URT_SRC_LINE    = 4'b0110,
        URT_SRC_TMO     = 4'b1100,
        URT_SRC_RXD     = 4'b0100,
        URT_SRC_TXE     = 4'b0010,
        URT_SRC_MODEM   = 4'b0000,
        URT_SRC_NONE    = 4'b0001
    } urt_src_t;
endpackage

/* rtl/urt_fifo.sv */
// Synchronous FIFO with valid/ready on both sides and registered read data.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module urt_fifo #(
    parameter int W  = 8,
    parameter int D  = 16,
    parameter int AW = 4
) (
    input  wire logic          mclk,
    input  wire logic          srst,
    input  wire logic          flush,
    input  wire logic          in_valid,
    input  wire logic [W-1:0]  in_data,
    output logic               in_ready,
    output logic               out_valid,
    output logic [W-1:0]       out_data,
    input  wire logic          out_ready,
    output logic [AW:0]        level
);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic [AW:0]   cnt_d;
    logic          push;
    logic          pop;

    assign push  = in_valid & in_ready;
    assign pop   = out_ready & out_valid;
    assign level = cnt_q;

    always_comb begin
        cnt_d = cnt_q;
        if (push & ~pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop & ~push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
        out_data <= mem[rp_q];
    end

    // Valid lags a push or pop by one cycle so the registered head is settled
    always_ff @(posedge mclk) begin
        if (srst | flush) begin
            wp_q      <= '0;
            rp_q      <= '0;
            cnt_q     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q     <= cnt_d;
            in_ready  <= cnt_d != (AW+1)'(D);
            out_valid <= (cnt_q != '0) & ~pop;
        end
    end
endmodule

/* rtl/urt_chan_regs.sv */
// Register decode and interrupt logic of one asynchronous serial channel.
// Assumes a host on asynchronous bus pins, and shifters on the same clock.
//
// Summary of operation
// R1 - Enable bits gate the four sources before they reach interrupt status.
// R2 - FIFO receive interrupt follows level at or above trigger.
// R3 - Receive status code and output clear when level drops below trigger.
// R4 - Data-ready sets when a character enters the FIFO, clears when empty.
// R5 - FIFOs on with enables cleared gives polled operation via line status.
// R6 - Line status bit 1 flags a receive overrun.
// R7 - Bits 2 to 4 show error tags of the head character.
// R8 - Bit 5 transmit holding empty; bit 6 holding and shifter empty.
// R9 - Bit 7 set in FIFO mode while any stored character carries an error tag.
// R10 - Receive interrupt on a held character, or trigger reached in FIFO mode.
// R11 - Transmit-empty interrupt, immediate if already empty when enabled.
// R12 - Line-status interrupt from line status bits 1 to 4.
// R13 - Overrun interrupts at once; tags interrupt when reaching the head.
// R14 - Enable bit 3 gates modem status; bits 7 to 4 reserved.
// R15 - Status shows only the highest pending source; bit 0 high when idle.
// R16 - Status bits 7 and 6 follow the FIFO enable.
// R17 - Transmit interrupt cleared by status read or transmit write.
// R18 - Line status read clears line interrupt; modem read clears modem one.
// R19 - Divisor enable maps offsets 0 and 1 onto the divisor bytes.
// R20 - Offset 0 reads receive, writes transmit; offset 2 status/FIFO control.
`timescale 1ns/10ps
`include "urt_cfg.svh"
module urt_chan_regs #(
    parameter int DEPTH = `URT_FIFO_DEPTH
) (
    input  wire logic              mclk,
    input  wire logic              srst,
    input  wire logic              host_cs_n,
    input  wire logic              host_rd_n,
    input  wire logic              host_wr_n,
    input  wire urt_pkg::urt_addr_t host_addr,
    input  wire urt_pkg::urt_byte_t host_data_in,
    output urt_pkg::urt_byte_t     host_data_out,
    output logic                   host_data_oe_n,
    input  wire logic              rx_push,
    input  wire urt_pkg::urt_byte_t rx_byte,
    input  wire logic [2:0]        rx_err,
    output logic                   rx_accept,
    input  wire logic              rx_timeout,
    output urt_pkg::urt_byte_t     tx_byte,
    output logic                   tx_valid,
    input  wire logic              tx_take,
    input  wire logic              tx_shifter_empty,
    input  wire logic              cts_n,
    input  wire logic              dsr_n,
    input  wire logic              ri_n,
    input  wire logic              cd_n,
    output logic                   rts_n,
    output logic                   dtr_n,
    output logic                   spare_output_one_n,
    output logic                   irq,
    output logic [15:0]            divisor,
    output urt_pkg::urt_byte_t     line_control,
    output logic                   loopback
);
    import urt_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [17:0] pin_s1_q;
    logic [17:0] pin_s2_q;
    logic        rd_act;
    logic        wr_act;
    logic        rd_act_q;
    logic        wr_act_q;
    logic        rd_go;
    logic        wr_go;
    urt_addr_t   addr;
    urt_byte_t   wdat;
    logic [3:0]  mpin;

    // Bus pins are asynchronous to mclk; strobes are acted on at their start
    always_ff @(posedge mclk) begin
        pin_s1_q <= {host_cs_n, host_rd_n, host_wr_n, host_addr, host_data_in,
                     cd_n, ri_n, dsr_n, cts_n};
        pin_s2_q <= pin_s1_q;
    end

    assign rd_act = ~pin_s2_q[17] & ~pin_s2_q[16];
    assign wr_act = ~pin_s2_q[17] & ~pin_s2_q[15];
    assign addr   = pin_s2_q[14:12];
    assign wdat   = pin_s2_q[11:4];
    assign mpin   = ~pin_s2_q[3:0];

    always_ff @(posedge mclk) begin
        if (srst) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
        end else begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
        end
    end

    assign rd_go = rd_act & ~rd_act_q;
    assign wr_go = wr_act & ~wr_act_q;

    // ****************************************
    // Control registers
    // ****************************************
    logic [3:0] ien_q;
    urt_byte_t  lcr_q;
    logic [4:0] mcr_q;
    urt_byte_t  spr_q;
    urt_byte_t  dll_q;
    urt_byte_t  dlm_q;
    logic       fifo_en_q;
    logic       dma_q;
    logic [1:0] trig_q;
    logic       dlab;
    logic       wr_hold;
    logic       wr_fcr;
    logic       rx_flush;
    logic       tx_flush;

    assign dlab    = lcr_q[`URT_LCTL_DIVEN];
    assign wr_hold = wr_go & (addr == `URT_OFS_HOLD) & ~dlab; // [R20]
    assign wr_fcr  = wr_go & (addr == `URT_OFS_ISTAT);         // [R20]

    // Toggling the FIFO enable empties both FIFOs so old bytes never leak out
    assign rx_flush = wr_fcr & (wdat[`URT_FCTL_EN]
                      ? (wdat[`URT_FCTL_RXCLR] | ~fifo_en_q) : fifo_en_q);
    assign tx_flush = wr_fcr & (wdat[`URT_FCTL_EN]
                      ? (wdat[`URT_FCTL_TXCLR] | ~fifo_en_q) : fifo_en_q);

    always_ff @(posedge mclk) begin
        if (srst) begin
            ien_q <= 4'h0;
            lcr_q <= `URT_RST_BYTE;
            mcr_q <= 5'h00;
            spr_q <= `URT_RST_BYTE;
            dll_q <= `URT_RST_BYTE;
            dlm_q <= `URT_RST_BYTE;
        end else if (wr_go) begin
            unique case (addr)
                `URT_OFS_HOLD: begin
                    if (dlab) begin
                        dll_q <= wdat; // [R19]
                    end
                end
                `URT_OFS_IEN: begin
                    if (dlab) begin
                        dlm_q <= wdat; // [R19]
                    end else begin
                        ien_q <= wdat[3:0]; // [R14]
                    end
                end
                `URT_OFS_LCTL: lcr_q <= wdat;
                `URT_OFS_MCTL: mcr_q <= wdat[4:0];
                `URT_OFS_SCR:  spr_q <= wdat;
                default: begin
                end
            endcase
        end
    end

    // Other bits only take effect while the enable bit is written as one
    always_ff @(posedge mclk) begin
        if (srst) begin
            fifo_en_q <= 1'b0;
            dma_q     <= 1'b0;
            trig_q    <= 2'h0;
        end else if (wr_fcr) begin
            fifo_en_q <= wdat[`URT_FCTL_EN];
            if (wdat[`URT_FCTL_EN]) begin
                dma_q  <= wdat[`URT_FCTL_DMA];
                trig_q <= wdat[7:6];
            end
        end
    end

    function automatic logic [4:0] trig_level(input logic [1:0] sel);
        unique case (sel)
            2'h0: trig_level = `URT_TRIG_L0;
            2'h1: trig_level = `URT_TRIG_L1;
            2'h2: trig_level = `URT_TRIG_L2;
            2'h3: trig_level = `URT_TRIG_L3;
        endcase
    endfunction

    // ****************************************
    // Receive path
    // ****************************************
    logic        rd_rhr;
    logic        rx_in_valid;
    logic        rx_vld;
    logic [10:0] rx_head;
    logic [4:0]  rx_lvl;
    logic        rx_vld_q;
    logic        ovr_evt;
    logic        ovr_q;
    logic [4:0]  err_cnt_q;
    logic        rx_pop;
    logic        rx_nonempty;
    logic [2:0]  head_err;

    assign rd_rhr      = rd_go & (addr == `URT_OFS_HOLD) & ~dlab; // [R20]
    assign rx_pop      = rd_rhr & rx_vld;
    assign rx_nonempty = rx_lvl != 5'h00;

    // Without FIFOs only one character is held; a second one overruns
    assign rx_in_valid = rx_push & (fifo_en_q | ~rx_nonempty);
    assign ovr_evt     = rx_push & (~rx_accept | (~fifo_en_q & rx_nonempty));
    assign head_err    = rx_head[10:8] & {3{rx_vld}};                 // [R7]

    urt_fifo #(.W(11), .D(DEPTH), .AW(4)) u_rx_fifo (
        .mclk      (mclk),
        .srst      (srst),
        .flush     (rx_flush),
        .in_valid  (rx_in_valid),
        .in_data   ({rx_err, rx_byte}),
        .in_ready  (rx_accept),
        .out_valid (rx_vld),
        .out_data  (rx_head),
        .out_ready (rx_pop),
        .level     (rx_lvl)
    );

    // Counts stored characters carrying any error tag
    always_ff @(posedge mclk) begin
        if (srst | rx_flush) begin
            err_cnt_q <= 5'h00;
        end else begin
            unique case ({rx_in_valid & rx_accept & (|rx_err),
                          rx_pop & (|rx_head[10:8])})
                2'b10:   err_cnt_q <= err_cnt_q + 1'b1; // [R9]
                2'b01:   err_cnt_q <= err_cnt_q - 1'b1; // [R9]
                default: err_cnt_q <= err_cnt_q;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_vld_q <= 1'b0;
        end else begin
            rx_vld_q <= rx_vld;
        end
    end

    // ****************************************
    // Transmit path
    // ****************************************
    logic [4:0] tx_lvl;
    logic       tx_rdy;
    logic       thre;
    logic       thre_q;
    logic       ien_tx_q;

    urt_fifo #(.W(8), .D(DEPTH), .AW(4)) u_tx_fifo (
        .mclk      (mclk),
        .srst      (srst),
        .flush     (tx_flush),
        .in_valid  (wr_hold & (fifo_en_q | thre)),
        .in_data   (wdat),
        .in_ready  (tx_rdy),
        .out_valid (tx_valid),
        .out_data  (tx_byte),
        .out_ready (tx_take),
        .level     (tx_lvl)
    );

    // Holding register (or FIFO) empty once the shifter took the last byte
    assign thre = tx_lvl == 5'h00; // [R8]

    always_ff @(posedge mclk) begin
        if (srst) begin
            thre_q   <= 1'b1;
            ien_tx_q <= 1'b0;
        end else begin
            thre_q   <= thre;
            ien_tx_q <= ien_q[`URT_IEN_TXE];
        end
    end

    // ****************************************
    // Modem status
    // ****************************************
    logic [3:0] mst;
    logic [3:0] mst_q;
    logic [3:0] dlt_q;
    logic [3:0] dlt_set;
    logic       rd_msr;

    // Loopback feeds the modem inputs from the control outputs
    assign mst     = mcr_q[4] ? {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]} : mpin;
    assign rd_msr  = rd_go & (addr == `URT_OFS_MSTAT);
    assign dlt_set = {mst[3] ^ mst_q[3], ~mst[2] & mst_q[2],
                      mst[1] ^ mst_q[1], mst[0] ^ mst_q[0]};

    always_ff @(posedge mclk) begin
        if (srst) begin
            mst_q <= 4'h0;
            dlt_q <= 4'h0;
        end else begin
            mst_q <= mst;
            dlt_q <= (dlt_q & {4{~rd_msr}}) | dlt_set; // [R18]
        end
    end

    // ****************************************
    // Interrupt sources and priority
    // ****************************************
    logic     rd_isr;
    logic     rd_lsr;
    logic     ls_q;
    logic     ls_set;
    logic     txi_q;
    logic     txi_set;
    logic     p_ls;
    logic     p_to;
    logic     p_rx;
    logic     p_tx;
    logic     p_ms;
    logic     rx_hit;
    urt_src_t src;

    assign rd_isr = rd_go & (addr == `URT_OFS_ISTAT);
    assign rd_lsr = rd_go & (addr == `URT_OFS_LSTAT);

    // Overrun raises at once; tags only when their character becomes the head
    assign ls_set = ovr_evt | (rx_vld & ~rx_vld_q & (|rx_head[10:8])); // [R13]

    // Fires on becoming empty, or on enabling while already empty
    assign txi_set = ien_q[`URT_IEN_TXE] & thre
                     & (~thre_q | ~ien_tx_q); // [R11]

    assign rx_hit = fifo_en_q ? (rx_lvl >= trig_level(trig_q)) // [R2] [R3]
                              : rx_nonempty;                   // [R10]

    assign p_ls = ien_q[`URT_IEN_LS] & ls_q;                   // [R1] [R12]
    assign p_to = ien_q[`URT_IEN_RXD] & fifo_en_q & rx_timeout & rx_nonempty;
    assign p_rx = ien_q[`URT_IEN_RXD] & rx_hit;                // [R1] [R10]
    assign p_tx = ien_q[`URT_IEN_TXE] & txi_q;                 // [R1]
    assign p_ms = ien_q[`URT_IEN_MS] & (|dlt_q);               // [R1] [R14]

    always_comb begin
        if (p_ls) begin
            src = URT_SRC_LINE; // [R15]
        end else if (p_to) begin
            src = URT_SRC_TMO;
        end else if (p_rx) begin
            src = URT_SRC_RXD;
        end else if (p_tx) begin
            src = URT_SRC_TXE;
        end else if (p_ms) begin
            src = URT_SRC_MODEM;
        end else begin
            src = URT_SRC_NONE;
        end
    end

    // A new event in the clearing cycle is kept: set wins over clear
    always_ff @(posedge mclk) begin
        if (srst) begin
            ls_q  <= 1'b0;
            ovr_q <= 1'b0;
            txi_q <= 1'b0;
        end else begin
            ls_q  <= (ls_q & ~rd_lsr) | ls_set;                // [R18]
            ovr_q <= (ovr_q & ~rd_lsr) | ovr_evt;              // [R6]
            txi_q <= (txi_q & ~wr_hold
                      & ~(rd_isr & (src == URT_SRC_TXE))) | txi_set; // [R17]
        end
    end

    // ****************************************
    // Read data and outputs
    // ****************************************
    urt_byte_t rd_val;
    urt_byte_t lsr_val;

    // Polled use relies on these bits alone when all enables are clear [R5]
    assign lsr_val = {fifo_en_q & (err_cnt_q != 5'h00), // [R9]
                      thre & tx_shifter_empty,          // [R8]
                      thre,                             // [R8]
                      head_err,                         // [R7]
                      ovr_q,                            // [R6]
                      rx_nonempty};                     // [R4]

    always_comb begin
        unique case (addr)
            `URT_OFS_HOLD:  rd_val = dlab ? dll_q : rx_head[7:0];     // [R19]
            `URT_OFS_IEN:   rd_val = dlab ? dlm_q : {4'h0, ien_q};    // [R14]
            `URT_OFS_ISTAT: rd_val = {{2{fifo_en_q}}, 2'h0, src};    // [R16]
            `URT_OFS_LCTL:  rd_val = lcr_q;
            `URT_OFS_MCTL:  rd_val = {3'h0, mcr_q};
            `URT_OFS_LSTAT: rd_val = lsr_val;
            `URT_OFS_MSTAT: rd_val = {mst_q, dlt_q};
            `URT_OFS_SCR:   rd_val = spr_q;
        endcase
    end

    // Data is captured at strobe start and held while the strobe lasts
    always_ff @(posedge mclk) begin
        if (srst) begin
            host_data_out  <= `URT_RST_BYTE;
            host_data_oe_n <= 1'b1;
        end else begin
            if (rd_go) begin
                host_data_out <= rd_val;
            end
            host_data_oe_n <= ~(rd_act & rd_act_q);
        end
    end

    // Interrupt line is gated by the modem control output gate bit
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq                <= 1'b0;
            rts_n              <= 1'b1;
            dtr_n              <= 1'b1;
            spare_output_one_n <= 1'b1;
            loopback           <= 1'b0;
        end else begin
            irq                <= (src != URT_SRC_NONE) & mcr_q[`URT_MCTL_GATE];
            rts_n              <= ~mcr_q[1] | mcr_q[4];
            dtr_n              <= ~mcr_q[0] | mcr_q[4];
            spare_output_one_n <= ~mcr_q[2];
            loopback           <= mcr_q[4];
        end
    end

    assign divisor      = {dlm_q, dll_q};
    assign line_control = lcr_q;
endmodule

/* verif/urt_chan_regs_assertions.sv */
// Concurrent checks on the ports of the serial channel register block.
// Assumes binding into urt_chan_regs; one clock, synchronous reset.
`timescale 1ns/10ps
module urt_chan_regs_checker (
    input wire logic               mclk,
    input wire logic               srst,
    input wire logic               host_cs_n,
    input wire logic               host_rd_n,
    input wire logic               host_wr_n,
    input wire logic               host_data_oe_n,
    input wire logic               irq,
    input wire logic               rts_n,
    input wire logic               dtr_n,
    input wire logic               spare_output_one_n,
    input wire logic               loopback,
    input wire logic               rx_push,
    input wire logic               rx_accept,
    input wire logic               tx_valid,
    input wire logic               tx_take,
    input wire urt_pkg::urt_byte_t tx_byte
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    a_oe_read: assert property ($fell(host_rd_n) && !host_cs_n |-> ##[3:7] !host_data_oe_n)
        else $error("read strobe got no data drive");
    a_oe_idle: assert property (host_cs_n [*6] |-> host_data_oe_n)
        else $error("data bus driven while deselected");
    a_oe_write: assert property (!host_wr_n [*6] |-> host_data_oe_n)
        else $error("data bus driven during a write");
    a_rst_values: assert property ($fell(srst) |-> !irq && host_data_oe_n && rts_n && dtr_n
        && spare_output_one_n && !tx_valid && rx_accept)
        else $error("outputs wrong after reset");
    a_loop_forces: assert property (loopback && $past(loopback) |-> rts_n && dtr_n)
        else $error("modem outputs active in loopback");
    a_rx_room: assert property ($fell(rx_accept) |-> $past(rx_push))
        else $error("receive room lost without a push");
    a_accept_rise: assert property ($rose(rx_accept) |-> !host_cs_n)
        else $error("receive room grew without host access");
    a_tx_hold: assert property (tx_valid && !tx_take |=> tx_valid && $stable(tx_byte))
        else $error("transmit head changed while not taken");
endmodule

/* verif/urt_host_model.sv */
// Host processor model speaking the asynchronous strobe bus.
// Assumes the channel samples strobes through a two-flop synchroniser.
`timescale 1ns/10ps
module urt_host_model (
    input  wire logic               mclk,
    output logic                    cs_n,
    output logic                    rd_n,
    output logic                    wr_n,
    output urt_pkg::urt_addr_t      addr,
    output urt_pkg::urt_byte_t      wdata,
    input  wire urt_pkg::urt_byte_t rdata
);
    import urt_pkg::*;
    initial begin
        {cs_n, rd_n, wr_n} = 3'h7;
        addr = 3'h0;
        wdata = 8'h00;
    end
    // Six cycles low covers sync lag plus answer; five idle lets the drive fall away
    task automatic access(input logic w, input urt_addr_t a, input urt_byte_t d,
                          output urt_byte_t q);
        @(negedge mclk);
        addr = a;
        wdata = d;
        cs_n = 1'b0;
        rd_n = w;
        wr_n = !w;
        repeat (6) @(negedge mclk);
        q = rdata;
        {cs_n, rd_n, wr_n} = 3'h7;
        // Released lines must not keep looking valid
        wdata = ~d;
        addr = ~a;
        repeat (5) @(negedge mclk);
    endtask
endmodule

/* verif/test_uart_reg_map_int_enable.sv */
// Self-checking bench for the serial channel register block.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/10ps
module test_uart_reg_map_int_enable;
    import urt_pkg::*;
    logic      mclk, srst, cs_n, rd_n, wr_n, oe_n, rx_push, rx_accept, tx_valid;
    logic      tx_take, sh_empty, cts_n, rts_n, dtr_n, sp_n, irq, lpbk;
    urt_addr_t addr;
    urt_byte_t wdata, rdata, rx_byte, tx_byte, lctl, q;
    logic [2:0]  rx_err;
    logic [15:0] div;
    int        failures, total_checks;

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    urt_host_model host (.mclk(mclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
        .wdata(wdata), .rdata(rdata));
    urt_chan_regs dut (.mclk(mclk), .srst(srst), .host_cs_n(cs_n), .host_rd_n(rd_n),
        .host_wr_n(wr_n), .host_addr(addr), .host_data_in(wdata), .host_data_out(rdata),
        .host_data_oe_n(oe_n), .rx_push(rx_push), .rx_byte(rx_byte), .rx_err(rx_err),
        .rx_accept(rx_accept), .rx_timeout(1'b0), .tx_byte(tx_byte), .tx_valid(tx_valid),
        .tx_take(tx_take), .tx_shifter_empty(sh_empty), .cts_n(cts_n), .dsr_n(1'b1),
        .ri_n(1'b1), .cd_n(1'b1), .rts_n(rts_n), .dtr_n(dtr_n), .spare_output_one_n(sp_n),
        .irq(irq), .divisor(div), .line_control(lctl), .loopback(lpbk));

    // ****************************************
    // Tasks
    // ****************************************
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task rd(input urt_addr_t a, input urt_byte_t e);
        host.access(1'b0, a, 8'h00, q);
        chk($sformatf("offset %0d", a), q, e);
    endtask
    task wr(input urt_addr_t a, input urt_byte_t d);
        host.access(1'b1, a, d, q);
    endtask
    task push(input urt_byte_t b, input logic [2:0] e);
        @(negedge mclk);
        rx_push = 1'b1;
        rx_byte = b;
        rx_err = e;
        @(negedge mclk);
        rx_push = 1'b0;
        // Head, line flag and irq register need three more edges to settle
        repeat (3) @(negedge mclk);
    endtask
    task pop;
        @(negedge mclk);
        tx_take = 1'b1;
        @(negedge mclk);
        tx_take = 1'b0;
        repeat (3) @(negedge mclk);
    endtask
    task give_verdict;
        $display("Checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        give_verdict;
    end
    initial begin
        {srst, sh_empty, cts_n} = 3'h7;
        {rx_push, tx_take, rx_err, rx_byte} = 13'h0;
        repeat (2) @(negedge mclk);
        srst = 1'b0;
        repeat (3) @(negedge mclk);
        rd(3'h1, 8'h00);
        rd(3'h2, 8'h01);
        rd(3'h5, 8'h60);
        wr(3'h7, 8'hA5);
        rd(3'h7, 8'hA5);
        wr(3'h3, 8'h83);
        wr(3'h0, 8'h34);
        wr(3'h1, 8'h12);
        rd(3'h0, 8'h34);
        wr(3'h3, 8'h03);
        wr(3'h1, 8'hF8);
        chk("divisor", div, 16'h1234);
        chk("line_control", lctl, 8'h03);
        rd(3'h1, 8'h08);
        wr(3'h4, 8'h0B);
        chk("rts_n", rts_n, 1'b0);
        chk("dtr_n", dtr_n, 1'b0);
        cts_n = 1'b0;
        repeat (8) @(negedge mclk);
        chk("irq", irq, 1'b1);
        rd(3'h2, 8'h00);
        rd(3'h6, 8'h11);
        chk("irq", irq, 1'b0);
        wr(3'h2, 8'h41);
        rd(3'h2, 8'hC1);
        wr(3'h1, 8'h00);
        for (int i = 0; i < 4; i++) begin
            push(8'h10 + 8'(i), 3'h0);
        end
        chk("irq", irq, 1'b0);
        rd(3'h5, 8'h61);
        wr(3'h1, 8'h01);
        chk("irq", irq, 1'b1);
        rd(3'h2, 8'hC4);
        rd(3'h0, 8'h10);
        chk("irq", irq, 1'b0);
        rd(3'h2, 8'hC1);
        rd(3'h0, 8'h11);
        rd(3'h0, 8'h12);
        rd(3'h5, 8'h61);
        rd(3'h0, 8'h13);
        rd(3'h5, 8'h60);
        wr(3'h1, 8'h02);
        chk("irq", irq, 1'b1);
        rd(3'h2, 8'hC2);
        chk("irq", irq, 1'b0);
        wr(3'h0, 8'h55);
        chk("tx_byte", {tx_valid, tx_byte}, 9'h155);
        rd(3'h5, 8'h00);
        sh_empty = 1'b0;
        pop;
        chk("irq", irq, 1'b1);
        rd(3'h5, 8'h20);
        wr(3'h0, 8'h66);
        chk("irq", irq, 1'b0);
        sh_empty = 1'b1;
        pop;
        chk("tx_valid", tx_valid, 1'b0);
        wr(3'h1, 8'h04);
        for (int i = 0; i < 3; i++) begin
            push(8'h3C, 3'h1 << i);
            chk("irq", irq, 1'b1);
            rd(3'h2, 8'hC6);
            rd(3'h5, 8'hE1 | (8'h04 << i));
            chk("irq", irq, 1'b0);
            rd(3'h0, 8'h3C);
        end
        push(8'h01, 3'h0);
        push(8'h02, 3'h2);
        chk("irq", irq, 1'b0);
        rd(3'h5, 8'hE1);
        rd(3'h0, 8'h01);
        chk("irq", irq, 1'b1);
        rd(3'h5, 8'hE9);
        rd(3'h0, 8'h02);
        for (int i = 0; i < 16; i++) begin
            push(8'(i), 3'h0);
        end
        chk("rx_accept", rx_accept, 1'b0);
        push(8'hEE, 3'h0);
        chk("irq", irq, 1'b1);
        rd(3'h5, 8'h63);
        for (int i = 0; i < 16; i++) begin
            rd(3'h0, 8'(i));
        end
        rd(3'h5, 8'h60);
        wr(3'h4, 8'h1B);
        rd(3'h4, 8'h1B);
        chk("rts_n", rts_n, 1'b1);
        chk("loopback", lpbk, 1'b1);
        give_verdict;
    end
endmodule

bind urt_chan_regs urt_chan_regs_checker chk_i (.mclk, .srst, .host_cs_n, .host_rd_n,
    .host_wr_n, .host_data_oe_n, .irq, .rts_n, .dtr_n, .spare_output_one_n, .loopback,
    .rx_push, .rx_accept, .tx_valid, .tx_take, .tx_byte);
